/* File: verilog/bbs_defs.svh */
// Constants for the block buffer serial readout: addresses, sizes, timing.
// Assumes the core clock is the 125 MHz reference clock.
`ifndef BBS_DEFS_SVH
`define BBS_DEFS_SVH
// Transfer addresses, first byte of every transfer
`define BBS_ADDR_WR1 8'ha1
`define BBS_ADDR_WR2 8'ha2
`define BBS_ADDR_RD 8'ha3
`define BBS_ADDR_W 8
// Buffer and word layout
`define BBS_DEPTH 24
`define BBS_DATA_W 16
`define BBS_FLAG_W 6
`define BBS_WR_W 16
// Release interval on the data-out line
`define BBS_CLK_PERIOD_NS 8
`define BBS_TDO_US 265
`define BBS_TDO_CYC ((`BBS_TDO_US * 1000 + `BBS_CLK_PERIOD_NS - 1) / `BBS_CLK_PERIOD_NS)
// Reset values
`define BBS_RST_ADDR 8'h00
`define BBS_RST_WR 16'h0000
`endif

/* File: verilog/bbs_pkg.sv */
// Types shared by the block buffer serial readout.
// Assumes nothing of its surroundings.
`default_nettype none
package bbs_pkg;
  typedef enum logic [1:0] {
    BBS_PH_IDLE = 2'b00,
    BBS_PH_WRITE1 = 2'b01,
    BBS_PH_WRITE2 = 2'b10,
    BBS_PH_READ = 2'b11
  } bbs_phase_e;
endpackage
`default_nettype wire

/* File: verilog/bbs_serial_readout.sv */
// Block buffer with serial readout port and read request on the data-out line.
// Assumes serial pins from outside the clock domain and block writes on ref_clk_in.
`include "bbs_defs.svh"
`default_nettype none
// Overview of operation
// - Each transfer opens with an 8-bit address
// - Two write kinds, one read kind
// - Buffer keeps up to 24 blocks with flags
// - New block pulls data-out line low
// - Line held high 265 us after readout
// - Empty buffer keeps line high afterwards
// - Unread blocks pull line low after release
// - High while unsynchronized, low on first block after sync
// - Request after empty safe for 480 ms
// - Remaining-block request safe for 20 ms
// - Several blocks readable in one select period
// - Read without request returns all zeros
// - Standby stops serial transfers
module bbs_serial_readout
  import bbs_pkg::*;
#(
  parameter int DEPTH = `BBS_DEPTH,
  parameter int DATA_W = `BBS_DATA_W,
  parameter int FLAG_W = `BBS_FLAG_W,
  parameter int WR_W = `BBS_WR_W,
  parameter int TDO_CYC = `BBS_TDO_CYC
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic chip_select_in,
  input wire logic serial_shift_tick_in,
  input wire logic serial_in_line_in,
  input wire logic test_select_pin_in,
  input wire logic standby_select_pin_in,
  input wire logic sync_reset_in,
  input wire logic synced_in,
  input wire logic blk_valid_in,
  input wire logic [DATA_W-1:0] blk_data_in,
  input wire logic [FLAG_W-1:0] blk_flags_in,
  output logic data_out_out,
  output logic data_out_oe_out,
  output logic [WR_W-1:0] first_write_transfer_out,
  output logic [WR_W-1:0] second_write_transfer_out,
  output logic wr_done_out
);
  localparam int WORD_W = DATA_W + FLAG_W + 2;
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam int BW = $clog2(WORD_W);
  localparam int RW = 16;

  if (DEPTH < 2 || DEPTH > 255 || WORD_W > 255 || WR_W < 2 || TDO_CYC < 2 ||
      TDO_CYC > 65535) begin : g_bad_param
    $error("bbs_serial_readout: unsupported parameter values");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a change counts once stages two and three agree
  logic [3:0] pin_raw;
  logic [3:0] pin_f_r;
  logic [3:0] pin_d_r;
  assign pin_raw = {standby_select_pin_in, serial_in_line_in, serial_shift_tick_in,
                    chip_select_in};
  // One process for all pins keeps a single driver on the filtered vectors
  logic [2:0] stg_r [4];
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < 4; i++) begin
        stg_r[i] <= 3'h0;
      end
      pin_f_r <= 4'h0;
      pin_d_r <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        stg_r[i] <= {stg_r[i][1:0], pin_raw[i]};
        if (stg_r[i][1] == stg_r[i][2]) begin
          pin_f_r[i] <= stg_r[i][2];
        end
      end
      pin_d_r <= pin_f_r;
    end
  end

  logic ce_f;
  logic di_f;
  logic ce_rise;
  logic ce_fall;
  logic cl_rise;
  logic stby;
  assign ce_f = pin_f_r[0];
  assign di_f = pin_f_r[2];
  assign ce_rise = pin_f_r[0] & ~pin_d_r[0];
  assign ce_fall = ~pin_f_r[0] & pin_d_r[0];
  assign cl_rise = pin_f_r[1] & ~pin_d_r[1];
  // Test mode is not served, so it also blocks the port
  assign stby = pin_f_r[3] | test_select_pin_in;

  ////////////////////////////////////////////////////////////////////////////
  // Block buffer
  logic [DATA_W-1:0] mem_data [DEPTH];
  logic [FLAG_W-1:0] mem_flag [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [CW-1:0] cnt_r;
  logic push;
  logic pop;
  logic load;
  logic full;
  bbs_phase_e phase_r;
  logic [BW-1:0] bit_r;
  logic [WORD_W-1:0] sh_r;
  logic [WORD_W-1:0] word_nxt;
  logic [`BBS_ADDR_W-1:0] addr_r;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign full = (cnt_r == CW'(DEPTH));
  assign push = blk_valid_in & synced_in & ~sync_reset_in;
  assign load = (ce_rise & ~stby & (addr_r == `BBS_ADDR_RD)) |
                ((phase_r == BBS_PH_READ) & cl_rise & (bit_r == BW'(WORD_W - 1)));
  assign pop = load & (cnt_r != '0) & ~sync_reset_in;

  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem_data[wr_ptr_r] <= blk_data_in;
      mem_flag[wr_ptr_r] <= blk_flags_in;
    end
  end

  // A full buffer drops its oldest block; the depth gives the host its margin
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in || sync_reset_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= ptr_inc(wr_ptr_r);
      end
      if (pop || (push && full)) begin
        rd_ptr_r <= ptr_inc(rd_ptr_r);
      end
      if (push && !pop && !full) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  // Empty flag marks the last buffered block, full flag a full buffer
  always_comb begin
    word_nxt = '0;
    if (cnt_r != '0) begin
      word_nxt = {mem_data[rd_ptr_r], mem_flag[rd_ptr_r], cnt_r == CW'(1), full};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial port
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      addr_r <= `BBS_RST_ADDR;
    end else if (cl_rise && !ce_f && !stby) begin
      addr_r <= {addr_r[`BBS_ADDR_W-2:0], di_f};
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      phase_r <= BBS_PH_IDLE;
    end else if (ce_fall || stby) begin
      phase_r <= BBS_PH_IDLE;
    end else if (ce_rise) begin
      case (addr_r)
        `BBS_ADDR_WR1: phase_r <= BBS_PH_WRITE1;
        `BBS_ADDR_WR2: phase_r <= BBS_PH_WRITE2;
        `BBS_ADDR_RD: phase_r <= BBS_PH_READ;
        default: phase_r <= BBS_PH_IDLE;
      endcase
    end
  end

  logic [WR_W-1:0] wsh_r;
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      wsh_r <= `BBS_RST_WR;
      first_write_transfer_out <= `BBS_RST_WR;
      second_write_transfer_out <= `BBS_RST_WR;
      wr_done_out <= 1'b0;
    end else begin
      wr_done_out <= 1'b0;
      if (cl_rise && (phase_r == BBS_PH_WRITE1 || phase_r == BBS_PH_WRITE2)) begin
        wsh_r <= {wsh_r[WR_W-2:0], di_f};
      end
      // Words take effect only when the select closes
      if (ce_fall && phase_r == BBS_PH_WRITE1) begin
        first_write_transfer_out <= wsh_r;
        wr_done_out <= 1'b1;
      end
      if (ce_fall && phase_r == BBS_PH_WRITE2) begin
        second_write_transfer_out <= wsh_r;
        wr_done_out <= 1'b1;
      end
    end
  end

  // Consecutive blocks follow without a gap inside one select period
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      sh_r <= '0;
      bit_r <= '0;
    end else if (load) begin
      sh_r <= word_nxt;
      bit_r <= '0;
    end else if (phase_r == BBS_PH_READ && cl_rise) begin
      sh_r <= {sh_r[WORD_W-2:0], 1'b0};
      bit_r <= bit_r + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data-out line: low drive means request or a zero data bit
  logic [RW-1:0] rel_r;
  logic rd_end;
  logic do_low_nxt;
  assign rd_end = ce_fall & (phase_r == BBS_PH_READ);

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      rel_r <= '0;
    end else if (rd_end) begin
      rel_r <= RW'(TDO_CYC);
    end else if (rel_r != '0) begin
      rel_r <= rel_r - 1'b1;
    end
  end

  // The empty buffer after sync reset keeps the line high until sync
  always_comb begin
    if (phase_r == BBS_PH_READ) begin
      do_low_nxt = ~sh_r[WORD_W-1];
    end else if (rel_r != '0) begin
      do_low_nxt = 1'b0;
    end else begin
      do_low_nxt = (cnt_r != '0);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      data_out_oe_out <= 1'b0;
      data_out_out <= 1'b0;
    end else begin
      data_out_oe_out <= do_low_nxt;
      data_out_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_read_closed;
    rd_end;
  endsequence
  sequence s_line_released;
    !data_out_oe_out [*8];
  endsequence

  rel_hold_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    s_read_closed |=> ##1 s_line_released)
    else $error("data-out not released after readout");
  rel_load_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    rd_end |=> rel_r == RW'(TDO_CYC))
    else $error("release interval not loaded");
  empty_high_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (rel_r == RW'(1) && cnt_r == '0 && !push && phase_r == BBS_PH_IDLE && !ce_rise)
    |-> ##2 !data_out_oe_out)
    else $error("line dropped with empty buffer");
  remain_low_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (rel_r == RW'(1) && cnt_r != '0 && phase_r == BBS_PH_IDLE && !ce_rise &&
     !sync_reset_in) |-> ##2 data_out_oe_out)
    else $error("no request with blocks remaining");
  request_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (push && cnt_r == '0 && rel_r == '0 && phase_r == BBS_PH_IDLE && !ce_f)
    |-> ##2 data_out_oe_out)
    else $error("new block raised no request");
  unsync_high_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (sync_reset_in && phase_r == BBS_PH_IDLE && !ce_rise && rel_r == '0)
    |-> ##2 !data_out_oe_out)
    else $error("line low after sync reset");
  zero_read_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (load && cnt_r == '0) |=> sh_r == '0)
    else $error("read without request not zero");
  consec_pop_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (pop && !sync_reset_in) |=> rd_ptr_r != $past(rd_ptr_r))
    else $error("next block not supplied");
  addr_shift_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (cl_rise && !ce_f && !stby) |=> addr_r[0] == $past(di_f))
    else $error("address bit not taken");
  cnt_bound_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    cnt_r <= CW'(DEPTH))
    else $error("buffer count above depth");
  shift_bit_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (phase_r == BBS_PH_READ && cl_rise && !load)
    |=> sh_r == {$past(sh_r[WORD_W-2:0]), 1'b0})
    else $error("read word not shifted");
  stby_block_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (stby && ce_rise) |=> phase_r == BBS_PH_IDLE)
    else $error("transfer started in standby");
  decode_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (ce_rise && !stby && addr_r == `BBS_ADDR_WR1) |=> phase_r == BBS_PH_WRITE1)
    else $error("write address not decoded");
endmodule
`default_nettype wire

/* File: tb/bbs_host_model.sv */
// Host bus master: drives select, shift clock and host data, samples the line.
// Assumes line_in already resolves the pull-up on the open-drain line.
`include "bbs_defs.svh"
`default_nettype none
module bbs_host_model (
  input wire logic ref_clk_in,
  input wire logic line_in,
  output logic cs_out,
  output logic tick_out,
  output logic di_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] got[$];
  initial begin
    cs_out = 1'b0;
    tick_out = 1'b0;
    di_out = 1'b1;
  end
  task automatic half();
    repeat (5) @(negedge ref_clk_in);
  endtask
  // Shift clock stands low outside frames
  task automatic shift_out(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      di_out = v[i];
      half();
      tick_out = 1'b1;
      half();
      tick_out = 1'b0;
    end
    // No pull on this wire, so the idle value must not mimic the last bit
    di_out = ~di_out;
  endtask
  task automatic write(input logic [7:0] a, input logic [15:0] d);
    shift_out({8'h00, a}, 8);
    half();
    cs_out = 1'b1;
    half();
    shift_out(d, 16);
    half();
    cs_out = 1'b0;
    half();
  endtask
  // Samples each bit just before the rise that advances it
  task automatic read(input int n);
    logic [23:0] w;
    shift_out({8'h00, `BBS_ADDR_RD}, 8);
    half();
    cs_out = 1'b1;
    repeat (4) half();
    for (int k = 0; k < n; k++) begin
      for (int i = 23; i >= 0; i--) begin
        w[i] = line_in;
        // The rise after the last wanted bit would already take the next block
        if (k < n - 1 || i > 0) begin
          tick_out = 1'b1;
          half();
          tick_out = 1'b0;
          half();
        end
      end
      got.push_back(w);
    end
    cs_out = 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: tb/test_block_buffer_serial_readout.sv */
// Self-checking bench for the block buffer serial readout.
// Assumes a host model on the serial pins and TDO_CYC shortened to 50.
`include "bbs_defs.svh"
`default_nettype none
`define BBS_TB_CHK(nm, e, g) begin n_compared++; if ((e) !== (g)) begin num_errors++; \
  $display("unexpected %s: expected %h seen %h", nm, e, g); end end
module test_block_buffer_serial_readout;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, standby, test_pin;
  logic sync_rst, synced, blk_valid;
  logic [15:0] blk_data;
  logic [5:0] blk_flags;
  logic dout, oe, wr_done, cs, tick, di, line;
  logic [15:0] wr1, wr2;
  int num_errors = 0, n_compared = 0, n_done = 0;
  assign line = oe ? dout : 1'b1;
  always #4 clk = ~clk;
  always @(posedge clk) if (wr_done === 1'b1) n_done++;
  bbs_serial_readout #(.TDO_CYC(50)) u_bbs_serial_readout (.ref_clk_in(clk),
    .rst_n_in(rst_n), .chip_select_in(cs), .serial_shift_tick_in(tick),
    .serial_in_line_in(di), .test_select_pin_in(test_pin),
    .standby_select_pin_in(standby), .sync_reset_in(sync_rst), .synced_in(synced),
    .blk_valid_in(blk_valid), .blk_data_in(blk_data), .blk_flags_in(blk_flags),
    .data_out_out(dout), .data_out_oe_out(oe), .first_write_transfer_out(wr1),
    .second_write_transfer_out(wr2), .wr_done_out(wr_done));
  bbs_host_model u_bbs_host_model (.ref_clk_in(clk), .line_in(line), .cs_out(cs),
    .tick_out(tick), .di_out(di));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic push(input logic [15:0] d);
    @(negedge clk);
    blk_valid = 1'b1;
    blk_data = d;
    blk_flags = d[5:0];
    @(negedge clk);
    blk_valid = 1'b0;
  endtask
  task automatic rd_chk(input logic [15:0] d, input logic e, input logic f);
    logic [23:0] w;
    w = u_bbs_host_model.got.pop_front();
    `BBS_TB_CHK("word", {d, d[5:0], e, f}, w)
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_unsynced();
    `BBS_TB_CHK("line idle", 1'b1, line)
    push(16'h1234);
    wait_cyc(6);
    `BBS_TB_CHK("line unsynced", 1'b1, line)
    u_bbs_host_model.read(1);
    rd_chk(16'h0000, 1'b0, 1'b0);
    wait_cyc(40);
    `BBS_TB_CHK("no own request", 1'b1, line)
    wait_cyc(60);
  endtask
  task automatic t_write();
    int d0;
    d0 = n_done;
    u_bbs_host_model.write(`BBS_ADDR_WR1, 16'h5a3c);
    `BBS_TB_CHK("wr1", 16'h5a3c, wr1)
    u_bbs_host_model.write(`BBS_ADDR_WR2, 16'hc3a5);
    `BBS_TB_CHK("wr2", 16'hc3a5, wr2)
    wait_cyc(2);
    `BBS_TB_CHK("done", d0 + 2, n_done)
    u_bbs_host_model.write(8'h55, 16'h0f0f);
    // Standby, then test pin: both must refuse the port
    for (int p = 0; p < 2; p++) begin
      {test_pin, standby} = (p == 0) ? 2'b01 : 2'b10;
      u_bbs_host_model.write(`BBS_ADDR_WR1, 16'h0f0f);
    end
    {test_pin, standby} = 2'b00;
    `BBS_TB_CHK("wr1 kept", 16'h5a3c, wr1)
    `BBS_TB_CHK("wr2 kept", 16'hc3a5, wr2)
    `BBS_TB_CHK("done kept", d0 + 2, n_done)
  endtask
  task automatic t_one();
    synced = 1'b1;
    push(16'h9e01);
    wait_cyc(4);
    `BBS_TB_CHK("request", 1'b0, line)
    u_bbs_host_model.read(1);
    rd_chk(16'h9e01, 1'b1, 1'b0);
    wait_cyc(40);
    `BBS_TB_CHK("release", 1'b1, line)
    wait_cyc(60);
    `BBS_TB_CHK("empty high", 1'b1, line)
  endtask
  task automatic t_multi();
    int c;
    push(16'h2a02);
    push(16'h2b03);
    push(16'h2c04);
    u_bbs_host_model.read(2);
    rd_chk(16'h2a02, 1'b0, 1'b0);
    rd_chk(16'h2b03, 1'b0, 1'b0);
    wait_cyc(40);
    `BBS_TB_CHK("release", 1'b1, line)
    c = 0;
    while (line !== 1'b0 && c < 60) begin
      wait_cyc(1);
      c++;
    end
    `BBS_TB_CHK("re-request", 1'b0, line)
    u_bbs_host_model.read(1);
    rd_chk(16'h2c04, 1'b1, 1'b0);
    wait_cyc(100);
  endtask
  task automatic t_full();
    for (int i = 0; i < 25; i++) push(16'h0100 + 16'(i));
    u_bbs_host_model.read(1);
    rd_chk(16'h0101, 1'b0, 1'b1);
    wait_cyc(70);
    `BBS_TB_CHK("left over", 1'b0, line)
    synced = 1'b0;
    @(negedge clk) sync_rst = 1'b1;
    @(negedge clk) sync_rst = 1'b0;
    wait_cyc(100);
    `BBS_TB_CHK("flushed", 1'b1, line)
    push(16'h3c05);
    wait_cyc(4);
    `BBS_TB_CHK("unsynced push", 1'b1, line)
    u_bbs_host_model.read(1);
    rd_chk(16'h0000, 1'b0, 1'b0);
    wait_cyc(100);
    synced = 1'b1;
    push(16'h3c05);
    wait_cyc(4);
    `BBS_TB_CHK("sync request", 1'b0, line)
    u_bbs_host_model.read(1);
    rd_chk(16'h3c05, 1'b1, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Tests need about 4600 cycles; the limit is over five times that
  initial begin
    repeat (25000) @(negedge clk);
    num_errors++;
    test_done();
  end
  initial begin
    standby = 1'b0;
    test_pin = 1'b0;
    sync_rst = 1'b0;
    synced = 1'b0;
    blk_valid = 1'b0;
    blk_data = 16'h0000;
    blk_flags = 6'h00;
    wait_cyc(16);
    rst_n = 1'b1;
    wait_cyc(4);
    t_unsynced();
    t_write();
    t_one();
    t_multi();
    t_full();
    test_done();
  end
endmodule
`default_nettype wire
